// [logic/rot_base_if.sv]
// Rotation bases shared between the loop control and the rename unit.
`timescale 1ns/1ps
`default_nettype none
interface rot_base_if;
   logic [6:0] gr_base;
   logic [6:0] gr_size;
   logic [6:0] fr_base;
   logic [5:0] pr_base;
   modport ctrl (output gr_base, output gr_size, output fr_base, output pr_base);
   modport rename (input gr_base, input gr_size, input fr_base, input pr_base);
endinterface : rot_base_if
`default_nettype wire

// [logic/rot_loop_ctrl.sv]
// Counted loop branch control with rotation bases and rotating predicates.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Physical number is arch number plus base.
// - Bases decrement only on loop branches.
// - Decrement moves X to X+1, wraps.
// - Predicates p16-p63 and floats f32-f127 rotate.
// - GR region zero or multiple of 8, max 96.
// - GR rotating region starts at r32.
// - Three bases all decrement together; the general base stays 0 at size 0, restarts on a same-cycle legal-size allocation.
// - Predicate move ignores predicate base.
// - Branch writes p63, lands in p16.
// - Branch decides, sets predicate, rotates, counts.
// - Kernel continue: rotate, p16=1, count down loop.
// - Epilog continue: rotate, p16=0, decrement epilog.
// - Epilog counter one means drained: exit.
// - Epilog counter zero is accepted.
// - Bottom branch taken on continue.
// - Exit branch taken on stop.
// - Final exit leaves both counters zero and p16 zero.
module rot_loop_ctrl (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic frame_alloc_i,
   input wire logic [6:0] frame_rot_size_i,
   input wire logic lc_write_i,
   input wire logic [63:0] lc_wdata_i,
   input wire logic ec_write_i,
   input wire logic [5:0] ec_wdata_i,
   input wire logic pred_move_i,
   input wire logic [47:0] pred_move_data_i,
   input wire logic loop_branch_i,
   input wire logic branch_is_exit_i,
   input wire logic [6:0] gr_arch_i,
   input wire logic [6:0] fr_arch_i,
   input wire logic [5:0] pr_arch_i,
   output logic branch_valid_o,
   output logic branch_taken_o,
   output logic alloc_error_o,
   output logic [1:0] loop_phase_o,
   output logic [63:0] loop_counter_o,
   output logic [5:0] epilog_counter_o,
   output logic [47:0] rot_pred_o,
   output logic [6:0] general_rotation_base_o,
   output logic [6:0] float_rotation_base_o,
   output logic [5:0] predicate_rotation_base_o,
   output logic [6:0] gr_phys_o,
   output logic [6:0] fr_phys_o,
   output logic [5:0] pr_phys_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [6:0] gr_base_q;
   logic [6:0] gr_size_q;
   logic [6:0] fr_base_q;
   logic [5:0] pr_base_q;
   logic [63:0] loop_counter_reg_q;
   logic [5:0] epilog_counter_reg_q;
   logic [47:0] pred_q;
   rot_loop_pkg::phase_e phase_d;
   rot_loop_pkg::phase_e phase_q;
   logic cont_d;
   logic size_ok;
   logic [47:0] pred_phys;
   logic [47:0] pred_rot;
   rot_base_if bases ();

   // ------------------------------------------------------------
   // Branch decision
   // ------------------------------------------------------------
   always_comb begin
      if (loop_counter_reg_q != 64'h0) begin
         phase_d = rot_loop_pkg::PH_KERNEL;
      end else if (epilog_counter_reg_q > 6'h01) begin
         phase_d = rot_loop_pkg::PH_EPILOG;
      end else begin
         phase_d = rot_loop_pkg::PH_EXIT;
      end
   end

   always_comb begin
      case (phase_d)
         rot_loop_pkg::PH_KERNEL: cont_d = 1'b1;
         rot_loop_pkg::PH_EPILOG: cont_d = 1'b1;
         default: cont_d = 1'b0;
      endcase
   end

   assign size_ok = (frame_rot_size_i[2:0] == 3'h0)
      && (frame_rot_size_i <= 7'(rot_loop_pkg::GR_MAX_ROT));

   // ------------------------------------------------------------
   // Rotation bases
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gr_size_q <= rot_loop_pkg::GR_SIZE_RST;
         alloc_error_o <= 1'b0;
      end else if (frame_alloc_i) begin
         alloc_error_o <= !size_ok;
         if (size_ok) begin
            gr_size_q <= frame_rot_size_i;
         end
      end
   end

   // Each base wraps within its own rotating region size so the rename add stays in range.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gr_base_q <= rot_loop_pkg::GR_BASE_RST;
         fr_base_q <= rot_loop_pkg::FR_BASE_RST;
         pr_base_q <= rot_loop_pkg::PR_BASE_RST;
      end else begin
         // An allocation of a legal size restarts only the general base; the fixed files keep rotating.
         if (frame_alloc_i && size_ok) begin
            gr_base_q <= rot_loop_pkg::GR_BASE_RST;
         end else if (loop_branch_i) begin
            if (gr_size_q == 7'h00) begin
               gr_base_q <= 7'h00;
            end else if (gr_base_q == 7'h00) begin
               gr_base_q <= gr_size_q - 7'h01;
            end else begin
               gr_base_q <= gr_base_q - 7'h01;
            end
         end
         if (loop_branch_i) begin
            fr_base_q <= (fr_base_q == 7'h00) ? 7'(rot_loop_pkg::FR_ROT_SIZE - 1)
               : fr_base_q - 7'h01;
            pr_base_q <= (pr_base_q == 6'h00) ? 6'(rot_loop_pkg::PR_ROT_SIZE - 1)
               : pr_base_q - 6'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         loop_counter_reg_q <= rot_loop_pkg::LC_RST;
      end else if (loop_branch_i) begin
         if (phase_d == rot_loop_pkg::PH_KERNEL) begin
            loop_counter_reg_q <= loop_counter_reg_q - 64'h1;
         end
      end else if (lc_write_i) begin
         loop_counter_reg_q <= lc_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         epilog_counter_reg_q <= rot_loop_pkg::EC_RST;
      end else if (loop_branch_i) begin
         if (phase_d != rot_loop_pkg::PH_KERNEL && epilog_counter_reg_q != 6'h00) begin
            epilog_counter_reg_q <= epilog_counter_reg_q - 6'h01;
         end
      end else if (ec_write_i) begin
         epilog_counter_reg_q <= ec_wdata_i;
      end
   end

   // ------------------------------------------------------------
   // Rotating predicates
   // ------------------------------------------------------------
   // Predicates are stored by physical slot; architectural view is rotated by base.
   // Shifting the stored vector would also work but would cost a 48-way mux per slot.
   genvar gi;
   generate
      for (gi = 0; gi < rot_loop_pkg::PR_ROT_SIZE; gi++) begin : g_pred
         localparam logic [6:0] SLOT = 7'(gi);
         logic [6:0] idx;
         always_comb begin
            idx = SLOT + 7'(pr_base_q);
            if (idx >= 7'(rot_loop_pkg::PR_ROT_SIZE)) begin
               idx = idx - 7'(rot_loop_pkg::PR_ROT_SIZE);
            end
         end
         assign pred_rot[gi] = pred_q[idx[5:0]];
      end
   endgenerate

   always_comb begin
      pred_phys = pred_q;
      // The top architectural slot p63 maps to physical slot (base-1) mod size.
      pred_phys[(pr_base_q == 6'h00) ? 6'(rot_loop_pkg::PR_ROT_SIZE - 1)
         : pr_base_q - 6'h01] = (phase_d == rot_loop_pkg::PH_KERNEL);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pred_q <= rot_loop_pkg::PR_RST;
      end else if (pred_move_i) begin
         pred_q <= pred_move_data_i;
      end else if (loop_branch_i) begin
         pred_q <= pred_phys;
      end
   end

   // ------------------------------------------------------------
   // Branch outcome and status outputs
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         branch_valid_o <= 1'b0;
         branch_taken_o <= 1'b0;
         phase_q <= rot_loop_pkg::PH_IDLE;
      end else begin
         branch_valid_o <= loop_branch_i;
         branch_taken_o <= loop_branch_i && (branch_is_exit_i ? !cont_d : cont_d);
         if (loop_branch_i) begin
            phase_q <= phase_d;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         loop_phase_o <= 2'b00;
         loop_counter_o <= 64'h0;
         epilog_counter_o <= 6'h00;
         rot_pred_o <= 48'h0;
         general_rotation_base_o <= 7'h00;
         float_rotation_base_o <= 7'h00;
         predicate_rotation_base_o <= 6'h00;
      end else begin
         loop_phase_o <= phase_q;
         loop_counter_o <= loop_counter_reg_q;
         epilog_counter_o <= epilog_counter_reg_q;
         rot_pred_o <= pred_rot;
         general_rotation_base_o <= gr_base_q;
         float_rotation_base_o <= fr_base_q;
         predicate_rotation_base_o <= pr_base_q;
      end
   end

   assign bases.gr_base = gr_base_q;
   assign bases.gr_size = gr_size_q;
   assign bases.fr_base = fr_base_q;
   assign bases.pr_base = pr_base_q;

   rot_rename u_rename (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .bases(bases),
      .gr_arch_i(gr_arch_i),
      .fr_arch_i(fr_arch_i),
      .pr_arch_i(pr_arch_i),
      .gr_phys_q(gr_phys_o),
      .fr_phys_q(fr_phys_o),
      .pr_phys_q(pr_phys_o)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_bases_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !loop_branch_i && !frame_alloc_i |=> $stable(fr_base_q) && $stable(pr_base_q)
      && $stable(gr_base_q))
      else $error("rotation base moved without a loop branch");
   chk_bases_together: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i |=> !$stable(fr_base_q) && !$stable(pr_base_q))
      else $error("bases did not decrement together");
   chk_kernel_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && !pred_move_i && loop_counter_reg_q != 64'h0 |=>
      loop_counter_reg_q == $past(loop_counter_reg_q) - 64'h1
      && epilog_counter_reg_q == $past(epilog_counter_reg_q) && pred_rot[0])
      else $error("kernel branch update wrong");
   chk_epilog_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && !pred_move_i && loop_counter_reg_q == 64'h0
      && epilog_counter_reg_q > 6'h01 |=>
      epilog_counter_reg_q == $past(epilog_counter_reg_q) - 6'h01 && !pred_rot[0])
      else $error("epilog branch update wrong");
   chk_drain_exit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && !branch_is_exit_i && loop_counter_reg_q == 64'h0
      && epilog_counter_reg_q <= 6'h01 |=> branch_valid_o && !branch_taken_o
      && epilog_counter_reg_q == 6'h00)
      else $error("drained loop did not exit");
   chk_exit_sense: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && branch_is_exit_i && loop_counter_reg_q != 64'h0 |=> !branch_taken_o)
      else $error("exit branch taken while continuing");
   chk_top_sense: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && !branch_is_exit_i && loop_counter_reg_q != 64'h0 |=> branch_taken_o)
      else $error("bottom branch not taken while continuing");
   chk_pred_shift: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && !pred_move_i |=> pred_rot[47:1] == $past(pred_rot[46:0]))
      else $error("predicates did not shift up by one");
   chk_pred_move: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pred_move_i |=> pred_q == $past(pred_move_data_i))
      else $error("predicate move applied an offset");
   chk_alloc_size: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      frame_alloc_i && !size_ok |=> gr_size_q == $past(gr_size_q) && alloc_error_o)
      else $error("illegal rotating size accepted");

   cov_kernel: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && phase_d == rot_loop_pkg::PH_KERNEL);
   cov_epilog: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && phase_d == rot_loop_pkg::PH_EPILOG);
   cov_exit_zero: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      loop_branch_i && epilog_counter_reg_q == 6'h00);
endmodule : rot_loop_ctrl
`default_nettype wire

// [logic/rot_loop_pkg.sv]
// Shared constants and types for register rotation and counted loop branches.
package rot_loop_pkg;
   localparam int GR_BASE_REG = 32;
   localparam int GR_MAX_ROT = 96;
   localparam int GR_ROT_GRAN = 8;
   localparam int FR_LO = 32;
   localparam int FR_HI = 127;
   localparam int FR_ROT_SIZE = FR_HI - FR_LO + 1;
   localparam int PR_LO = 16;
   localparam int PR_HI = 63;
   localparam int PR_ROT_SIZE = PR_HI - PR_LO + 1;
   localparam int GR_IDX_W = 7;
   localparam int FR_IDX_W = 7;
   localparam int PR_IDX_W = 6;
   localparam int CNT_W = 64;
   localparam logic [6:0] GR_BASE_RST = 7'h00;
   localparam logic [6:0] FR_BASE_RST = 7'h00;
   localparam logic [5:0] PR_BASE_RST = 6'h00;
   localparam logic [6:0] GR_SIZE_RST = 7'h00;
   localparam logic [CNT_W-1:0] LC_RST = 64'h0;
   localparam logic [5:0] EC_RST = 6'h00;
   localparam logic [PR_ROT_SIZE-1:0] PR_RST = 48'h0;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_KERNEL = 2'b01,
      PH_EPILOG = 2'b11,
      PH_EXIT = 2'b10
   } phase_e;
endpackage : rot_loop_pkg

// [logic/rot_rename.sv]
// Architectural-to-physical mapping for the three rotating register files.
`timescale 1ns/1ps
`default_nettype none
module rot_rename (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   rot_base_if.rename bases,
   input wire logic [6:0] gr_arch_i,
   input wire logic [6:0] fr_arch_i,
   input wire logic [5:0] pr_arch_i,
   output logic [6:0] gr_phys_q,
   output logic [6:0] fr_phys_q,
   output logic [5:0] pr_phys_q
);
   logic [7:0] gr_sum;
   logic [7:0] gr_off;
   logic [7:0] fr_sum;
   logic [6:0] pr_sum;
   logic [6:0] gr_d;
   logic [6:0] fr_d;
   logic [5:0] pr_d;

   // Bases count down, so modular add makes X appear at X+1 after a decrement.
   always_comb begin
      gr_d = gr_arch_i;
      gr_off = 8'(gr_arch_i) - 8'(rot_loop_pkg::GR_BASE_REG);
      gr_sum = gr_off + 8'(bases.gr_base);
      if (gr_arch_i >= 7'(rot_loop_pkg::GR_BASE_REG) && gr_off < 8'(bases.gr_size)) begin
         if (gr_sum >= 8'(bases.gr_size)) begin
            gr_sum = gr_sum - 8'(bases.gr_size);
         end
         gr_d = 7'(gr_sum + 8'(rot_loop_pkg::GR_BASE_REG));
      end
      fr_d = fr_arch_i;
      fr_sum = 8'(fr_arch_i) - 8'(rot_loop_pkg::FR_LO) + 8'(bases.fr_base);
      if (fr_arch_i >= 7'(rot_loop_pkg::FR_LO)) begin
         if (fr_sum >= 8'(rot_loop_pkg::FR_ROT_SIZE)) begin
            fr_sum = fr_sum - 8'(rot_loop_pkg::FR_ROT_SIZE);
         end
         fr_d = 7'(fr_sum + 8'(rot_loop_pkg::FR_LO));
      end
      pr_d = pr_arch_i;
      pr_sum = 7'(pr_arch_i) - 7'(rot_loop_pkg::PR_LO) + 7'(bases.pr_base);
      if (pr_arch_i >= 6'(rot_loop_pkg::PR_LO)) begin
         if (pr_sum >= 7'(rot_loop_pkg::PR_ROT_SIZE)) begin
            pr_sum = pr_sum - 7'(rot_loop_pkg::PR_ROT_SIZE);
         end
         pr_d = 6'(pr_sum + 7'(rot_loop_pkg::PR_LO));
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gr_phys_q <= 7'h00;
         fr_phys_q <= 7'h00;
         pr_phys_q <= 6'h00;
      end else begin
         gr_phys_q <= gr_d;
         fr_phys_q <= fr_d;
         pr_phys_q <= pr_d;
      end
   end
endmodule : rot_rename
`default_nettype wire

// [tb/loop_issue_model.sv]
// Partner model: decode front end that issues one counted software-pipelined loop.
`timescale 1ns/1ps
`default_nettype none
module loop_issue_model (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic go_i,
   input wire logic [63:0] trip_i,
   input wire logic [5:0] stages_i,
   input wire logic branch_valid_i,
   input wire logic branch_taken_i,
   output logic lc_write_o,
   output logic [63:0] lc_wdata_o,
   output logic ec_write_o,
   output logic [5:0] ec_wdata_o,
   output logic pred_move_o,
   output logic [47:0] pred_data_o,
   output logic loop_branch_o,
   output logic busy_o,
   output logic [15:0] count_o
);
   logic [1:0] st_q;
   // Each branch waits for its answer before the next is issued. This is slower than
   // real issue, but it lets the model follow the decision the way fetch would.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= 2'h0;
         lc_write_o <= 1'b0;
         ec_write_o <= 1'b0;
         pred_move_o <= 1'b0;
         loop_branch_o <= 1'b0;
         busy_o <= 1'b0;
         count_o <= 16'h0;
         lc_wdata_o <= 64'h0;
         ec_wdata_o <= 6'h0;
         pred_data_o <= 48'h0;
      end else begin
         lc_write_o <= 1'b0;
         ec_write_o <= 1'b0;
         pred_move_o <= 1'b0;
         loop_branch_o <= 1'b0;
         case (st_q)
            2'h0: begin
               // Data that is not qualified by a strobe keeps changing while idle.
               lc_wdata_o <= ~lc_wdata_o;
               ec_wdata_o <= ~ec_wdata_o;
               pred_data_o <= ~pred_data_o;
               if (go_i) begin
                  lc_write_o <= 1'b1;
                  lc_wdata_o <= trip_i - 64'h1;
                  ec_write_o <= 1'b1;
                  ec_wdata_o <= stages_i + 6'h1;
                  pred_move_o <= 1'b1;
                  pred_data_o <= 48'h1;
                  busy_o <= 1'b1;
                  count_o <= 16'h0;
                  st_q <= 2'h1;
               end
            end
            2'h1: begin
               loop_branch_o <= 1'b1;
               st_q <= 2'h2;
            end
            default: begin
               if (branch_valid_i) begin
                  count_o <= count_o + 16'h1;
                  busy_o <= branch_taken_i;
                  st_q <= branch_taken_i ? 2'h1 : 2'h0;
               end
            end
         endcase
      end
   end
endmodule : loop_issue_model
`default_nettype wire

// [tb/rot_loop_ctrl_bench.sv]
// Self-checking bench for the rotating register and counted loop branch block.
`timescale 1ns/1ps
`default_nettype none
module rot_loop_ctrl_bench;
   logic ref_clk_i, rst_n_i, alloc_b, lc_wr_b, ec_wr_b, pm_b, br_b, is_exit_b, go;
   logic [6:0] size_b, gr_a, fr_a, grb, frb, grp, frp;
   logic [5:0] pr_a, prb, prp, ec_d_b, ec_d_m, ec_o;
   logic [63:0] lc_d_b, lc_d_m, lc_o, trip;
   logic [47:0] pm_d_b, pm_d_m, pred_o;
   logic [5:0] stages;
   logic [1:0] phase;
   logic lc_wr_m, ec_wr_m, pm_m, br_m, busy_m, bv, bt, aerr;
   logic [15:0] cnt_m;
   int fails, compares, nb;

   rot_loop_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .frame_alloc_i(alloc_b),
      .frame_rot_size_i(size_b), .lc_write_i(lc_wr_b | lc_wr_m),
      .lc_wdata_i(busy_m ? lc_d_m : lc_d_b), .ec_write_i(ec_wr_b | ec_wr_m),
      .ec_wdata_i(busy_m ? ec_d_m : ec_d_b), .pred_move_i(pm_b | pm_m),
      .pred_move_data_i(busy_m ? pm_d_m : pm_d_b), .loop_branch_i(br_b | br_m),
      .branch_is_exit_i(is_exit_b), .gr_arch_i(gr_a), .fr_arch_i(fr_a), .pr_arch_i(pr_a),
      .branch_valid_o(bv), .branch_taken_o(bt), .alloc_error_o(aerr), .loop_phase_o(phase),
      .loop_counter_o(lc_o), .epilog_counter_o(ec_o), .rot_pred_o(pred_o),
      .general_rotation_base_o(grb), .float_rotation_base_o(frb),
      .predicate_rotation_base_o(prb), .gr_phys_o(grp), .fr_phys_o(frp), .pr_phys_o(prp));

   loop_issue_model partner (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .go_i(go),
      .trip_i(trip), .stages_i(stages), .branch_valid_i(bv), .branch_taken_i(bt),
      .lc_write_o(lc_wr_m), .lc_wdata_o(lc_d_m), .ec_write_o(ec_wr_m), .ec_wdata_o(ec_d_m),
      .pred_move_o(pm_m), .pred_data_o(pm_d_m), .loop_branch_o(br_m), .busy_o(busy_m),
      .count_o(cnt_m));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   task automatic final_report;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic pulse_wait;
      @(posedge ref_clk_i);
      {alloc_b, lc_wr_b, ec_wr_b, pm_b} <= 4'h0;
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask : pulse_wait

   task automatic alloc(input logic [6:0] s, input logic e);
      @(posedge ref_clk_i);
      alloc_b <= 1'b1;
      size_b <= s;
      pulse_wait();
      chk("alloc_error", aerr, e);
   endtask : alloc

   task automatic load(input logic [63:0] l, input logic [5:0] e);
      @(posedge ref_clk_i);
      {lc_wr_b, ec_wr_b} <= 2'h3;
      lc_d_b <= l;
      ec_d_b <= e;
      pulse_wait();
   endtask : load

   // The answer is sampled after the edge so the registered pulse has landed.
   task automatic branch(input logic ex, input logic exp_t);
      int k;
      k = 0;
      @(posedge ref_clk_i);
      br_b <= 1'b1;
      is_exit_b <= ex;
      @(posedge ref_clk_i);
      br_b <= 1'b0;
      #1;
      while (bv !== 1'b1 && k < 4) begin
         @(posedge ref_clk_i);
         #1;
         k++;
      end
      chk("branch_valid", bv, 1);
      chk("branch_taken", bt, exp_t);
      nb++;
      @(posedge ref_clk_i);
      #1;
   endtask : branch

   task automatic check_bases;
      chk("gr_base", grb, (16 - nb % 16) % 16);
      chk("fr_base", frb, (96 - nb % 96) % 96);
      chk("pr_base", prb, (48 - nb % 48) % 48);
      chk("gr_phys", grp, 32 + (1 + (16 - nb % 16) % 16) % 16);
      chk("fr_phys", frp, 32 + (96 - nb % 96) % 96);
      chk("pr_phys", prp, 16 + (48 - nb % 48) % 48);
   endtask : check_bases

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      #50000;
      fails++;
      final_report();
   end

   initial begin
      {rst_n_i, alloc_b, lc_wr_b, ec_wr_b, pm_b, br_b, is_exit_b, go} = 8'h0;
      {size_b, lc_d_b, ec_d_b, pm_d_b, trip, stages} = '0;
      {fails, compares, nb} = '0;
      gr_a = 7'h21;
      fr_a = 7'h20;
      pr_a = 6'h10;
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("reset_lc", lc_o, 0);
      chk("reset_ec", ec_o, 0);
      chk("reset_pred", pred_o, 0);
      chk("reset_phase", phase, 0);
      alloc(7'h64, 1'b1);
      alloc(7'h0c, 1'b1);
      alloc(7'h60, 1'b0);
      alloc(7'h10, 1'b0);
      @(posedge ref_clk_i);
      go <= 1'b1;
      trip <= 64'h5;
      stages <= 6'h3;
      @(posedge ref_clk_i);
      go <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      for (int k = 0; k < 100 && busy_m === 1'b1; k++) begin
         @(posedge ref_clk_i);
         #1;
      end
      chk("run_done", busy_m, 0);
      repeat (3) @(posedge ref_clk_i);
      #1;
      nb = 8;
      chk("branch_count", cnt_m, 8);
      chk("run_lc", lc_o, 0);
      chk("run_ec", ec_o, 0);
      chk("run_pred", pred_o, 48'h1f0);
      chk("run_phase", phase, 2'b10);
      check_bases();
      branch(1'b0, 1'b0);
      chk("ec_zero", ec_o, 0);
      branch(1'b1, 1'b1);
      chk("wrap_pred", pred_o, 48'h7c0);
      check_bases();
      load(64'h1, 6'h2);
      branch(1'b1, 1'b0);
      chk("k_phase", phase, 2'b01);
      chk("k_lc", lc_o, 0);
      chk("k_ec", ec_o, 2);
      chk("k_pred", pred_o, 48'hf81);
      branch(1'b0, 1'b1);
      chk("e_phase", phase, 2'b11);
      chk("e_ec", ec_o, 1);
      chk("e_pred", pred_o, 48'h1f02);
      branch(1'b0, 1'b0);
      chk("x_ec", ec_o, 0);
      chk("x_phase", phase, 2'b10);
      check_bases();
      @(posedge ref_clk_i);
      pm_b <= 1'b1;
      pm_d_b <= 48'h1;
      pulse_wait();
      chk("move_pred", pred_o, 64'h1 << (nb % 48));
      alloc(7'h00, 1'b0);
      branch(1'b0, 1'b0);
      chk("gr_zero_base", grb, 0);
      chk("gr_zero_phys", grp, 7'h21);
      final_report();
   end
endmodule : rot_loop_ctrl_bench
`default_nettype wire
